// ### rtl/csp_regs.vh
`ifndef CSP_REGS_VH
`define CSP_REGS_VH

// =========================================
// register addresses on the internal bus
`define CSP_MODE_CH0 16'hff80
`define CSP_CLKSEL_CH0 16'hff81
`define CSP_SHIFT_CH0 16'hff82
`define CSP_TXBUF_CH0 16'hff83
`define CSP_MODE_CH1 16'hff88
`define CSP_CLKSEL_CH1 16'hff89
`define CSP_SHIFT_CH1 16'hff8a
`define CSP_TXBUF_CH1 16'hff8b

// =========================================
// mode register fields
`define CSP_MODE_ENABLE 7
`define CSP_MODE_TXRX 6
`define CSP_MODE_SS_USE 5
`define CSP_MODE_DIR 4
`define CSP_MODE_ACTIVE 0

// =========================================
// clock selection register fields
`define CSP_CLK_POL 4
`define CSP_CLK_PHASE 3
`define CSP_CLK_SEL_HI 2
`define CSP_CLK_SEL_LO 0
`define CSP_CLK_SLAVE 3'h7

// =========================================
// reset values and counts
`define CSP_RESET_VAL 8'h00
`define CSP_BITS_LAST 3'h7
`define CSP_FIFO_DEPTH 16
`define CSP_FIFO_AW 4

`endif

// ### rtl/csp_clkdiv.v
`timescale 1ns/1ps
`include "csp_regs.vh"

// =========================================
// half-period tick for the master serial clock
module csp_clkdiv (
	input wire clock,
	input wire rst,
	input wire run,
	input wire [2:0] code,
	output wire half_tick
);
	reg [5:0] cnt;
	reg [5:0] limit;

	// code k gives a serial clock of clock/2^(k+1), so a half period of 2^k cycles
	always @* begin
		case (code)
			3'h0: limit = 6'h00;
			3'h1: limit = 6'h01;
			3'h2: limit = 6'h03;
			3'h3: limit = 6'h07;
			3'h4: limit = 6'h0f;
			3'h5: limit = 6'h1f;
			3'h6: limit = 6'h3f;
			default: limit = 6'h00;
		endcase
	end

	assign half_tick = run && (cnt == limit);

	// counter restarts with each transfer so the first edge is a full half period away
	always @(posedge clock) begin
		if (rst || !run || half_tick) begin
			cnt <= 6'h00;
		end else begin
			cnt <= cnt + 6'h01;
		end
	end
endmodule // csp_clkdiv

// ### rtl/csp_fifo.v
`timescale 1ns/1ps

// =========================================
// synchronous fifo with valid/ready on both sides
module csp_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire clock,
	input wire rst,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr;
	reg [AW-1:0] rd_ptr;
	reg [AW:0] count;
	wire push;
	wire pop;
	// occupancy at which the fifo refuses a push, sized to the counter
	localparam [AW:0] FULL_COUNT = DEPTH;

	assign in_ready = (count != FULL_COUNT);
	assign out_valid = (count != {(AW+1){1'b0}});
	assign out_data = mem[rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// storage has no reset; only the pointers and the count need a defined value
	always @(posedge clock) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// pointer and occupancy bookkeeping
	always @(posedge clock) begin
		if (rst) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
			end
			if (pop) begin
				rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
			end
			if (push && !pop) begin
				count <= count + {{AW{1'b0}}, 1'b1};
			end else if (pop && !push) begin
				count <= count - {{AW{1'b0}}, 1'b1};
			end
		end
	end
endmodule // csp_fifo

// ### rtl/csp_serial_ctrl.v
`timescale 1ns/1ps
`include "csp_regs.vh"

module csp_serial_ctrl (
	input wire clock,
	input wire rst,
	input wire [15:0] bus_addr,
	input wire bus_wr,
	input wire [7:0] bus_wdata,
	input wire bus_bit_wr,
	input wire [2:0] bus_bit_sel,
	input wire bus_bit_val,
	input wire bus_rd,
	output reg [7:0] bus_rdata,
	input wire [1:0] sck_in,
	output wire [1:0] sck_out,
	output wire [1:0] sck_oe_n,
	input wire [1:0] si,
	output wire [1:0] so,
	input wire slave_select_in_n,
	output wire [15:0] rx_data,
	output wire [1:0] rx_valid,
	input wire [1:0] rx_ready
);
	// =========================================
	// helpers

	// merge a byte write or a single-bit write into the old value
	function [7:0] merge_write;
		input [7:0] old;
		input byte_wr;
		input [7:0] wdata;
		input bit_wr;
		input [2:0] sel;
		input val;
		reg [7:0] tmp;
		begin
			tmp = old;
			if (byte_wr) begin
				tmp = wdata;
			end else if (bit_wr) begin
				tmp[sel] = val;
			end
			merge_write = tmp;
		end
	endfunction

	// bit that goes out next for the chosen order
	function out_bit;
		input [7:0] sh;
		input lsb_first;
		begin
			out_bit = lsb_first ? sh[0] : sh[7];
		end
	endfunction

	// shift one received bit in, moving out the bit just sent
	function [7:0] shift_in;
		input [7:0] sh;
		input lsb_first;
		input din;
		begin
			shift_in = lsb_first ? {din, sh[7:1]} : {sh[6:0], din};
		end
	endfunction

	// address match, shared by every register strobe of both channels
	function addr_hit;
		input [15:0] addr;
		input [15:0] base;
		begin
			addr_hit = (addr == base);
		end
	endfunction

	// =========================================
	// frame timing
	// a master frame is sixteen half periods of 2^code cycles each
	// the first clock change comes one full half period after the start
	// phase 0 puts the first bit out at the start and samples on leading edges
	// phase 1 moves data on leading edges and samples on trailing ones
	// the polarity bit doubles as the idle level of the driven clock
	// and so is also what an enabled master drives on the clock pin between frames
	// the busy flag drops on the eighth trailing edge
	// the received byte reaches the fifo one cycle after that
	// a slave sees edges by comparing the pin with its last sample,
	// so each clock level must last at least one cycle
	// clearing enable ends a frame at the next edge and empties the fifo;
	// this is a synchronous stand-in for an immediate channel reset
	// software must leave mode and clock fields alone while busy,
	// since a changed phase or order mid-frame would corrupt the byte
	// a full fifo holds off new starts, but a start while the last byte's push is still pending is not held off and can drop data
	// receive-only reception begins with a read of the shift register,
	// which returns the byte of the previous frame
	// the data pin is held low in receive-only mode and while disabled
	// the clock pin is driven only by an enabled master, else it is an input
	// channel 0 has no slave select, so its select-use bit reads zero

	// =========================================
	// per-channel state, gathered for the read mux
	wire [7:0] mode_rd [0:1];
	wire [7:0] clk_rd [0:1];
	wire [7:0] shift_rd [0:1];
	wire [7:0] txbuf_rd [0:1];

	genvar i;
	generate
		for (i = 0; i < 2; i = i + 1) begin : g_ch
			localparam [15:0] A_MODE = (i == 0) ? `CSP_MODE_CH0 : `CSP_MODE_CH1;
			localparam [15:0] A_CLK = (i == 0) ? `CSP_CLKSEL_CH0 : `CSP_CLKSEL_CH1;
			localparam [15:0] A_SHIFT = (i == 0) ? `CSP_SHIFT_CH0 : `CSP_SHIFT_CH1;
			localparam [15:0] A_TXBUF = (i == 0) ? `CSP_TXBUF_CH0 : `CSP_TXBUF_CH1;
			localparam HAS_SS = (i == 1);

			reg enable;
			reg txrx_mode;
			reg slave_select_use;
			reg bit_order;
			reg clock_polarity;
			reg data_phase;
			reg [2:0] clock_select;
			reg [7:0] transmit_buffer;
			reg [7:0] shift_reg;
			reg active;
			reg [2:0] bit_cnt;
			reg sample_bit;
			reg sck_drive;
			reg sck_prev;
			reg so_bit;
			wire [7:0] mode_val;
			wire [7:0] clk_val;
			wire [7:0] mode_next;
			wire [7:0] clk_next;
			wire wr_mode;
			wire wr_clk;
			wire wr_txbuf;
			wire rd_shift;
			wire slave;
			wire ss_ok;
			wire start;
			wire half_tick;
			wire lead_edge;
			wire trail_edge;
			wire sck_left_idle;
			wire sck_back_idle;
			wire [7:0] next_shift;
			wire fifo_in_ready;
			reg push;

			assign mode_val = {enable, txrx_mode, slave_select_use, bit_order, 3'h0, active};
			assign clk_val = {3'h0, clock_polarity, data_phase, clock_select};
			assign wr_mode = (bus_wr || bus_bit_wr) && addr_hit(bus_addr, A_MODE);
			assign wr_clk = (bus_wr || bus_bit_wr) && addr_hit(bus_addr, A_CLK);
			assign wr_txbuf = bus_wr && addr_hit(bus_addr, A_TXBUF);
			assign rd_shift = bus_rd && addr_hit(bus_addr, A_SHIFT);
			assign mode_next = merge_write(mode_val, bus_wr, bus_wdata, bus_bit_wr,
				bus_bit_sel, bus_bit_val);
			assign clk_next = merge_write(clk_val, bus_wr, bus_wdata, bus_bit_wr,
				bus_bit_sel, bus_bit_val);

			// =========================================
			// control registers; the active flag is not writable
			always @(posedge clock) begin
				if (rst) begin
					enable <= 1'b0;
					txrx_mode <= 1'b0;
					slave_select_use <= 1'b0;
					bit_order <= 1'b0;
					clock_polarity <= 1'b0;
					data_phase <= 1'b0;
					clock_select <= 3'h0;
					transmit_buffer <= `CSP_RESET_VAL;
				end else begin
					if (wr_mode) begin
						enable <= mode_next[`CSP_MODE_ENABLE];
						txrx_mode <= mode_next[`CSP_MODE_TXRX];
						// channel 0 has no slave select, so bit 5 stays zero there
						slave_select_use <= HAS_SS ? mode_next[`CSP_MODE_SS_USE] : 1'b0;
						bit_order <= mode_next[`CSP_MODE_DIR];
					end
					if (wr_clk) begin
						clock_polarity <= clk_next[`CSP_CLK_POL];
						data_phase <= clk_next[`CSP_CLK_PHASE];
						clock_select <= clk_next[`CSP_CLK_SEL_HI:`CSP_CLK_SEL_LO];
					end
					if (wr_txbuf && !active) begin
						transmit_buffer <= bus_wdata;
					end
				end
			end

			// =========================================
			// start decode
			assign slave = (clock_select == `CSP_CLK_SLAVE);
			assign ss_ok = !(HAS_SS && slave && slave_select_use) || !slave_select_in_n;
			// a new byte waits for room in the fifo count, which leaves out a push still pending, so the drain side stalls the port
			assign start = enable && !active && fifo_in_ready && ss_ok &&
				((txrx_mode && wr_txbuf) || (!txrx_mode && rd_shift));

			csp_clkdiv u_div (
				.clock(clock),
				.rst(rst),
				.run(active && !slave),
				.code(clock_select),
				.half_tick(half_tick)
			);

			// slave edge detect; the pin is sampled once per cycle
			assign sck_left_idle = (sck_prev == clock_polarity) && (sck_in[i] != clock_polarity);
			assign sck_back_idle = (sck_prev != clock_polarity) && (sck_in[i] == clock_polarity);
			// leading edge leaves the idle level, trailing edge returns to it
			assign lead_edge = active && (slave ?
				sck_left_idle :
				(half_tick && sck_drive == clock_polarity));
			assign trail_edge = active && (slave ?
				sck_back_idle :
				(half_tick && sck_drive != clock_polarity));
			// phase 0 samples on the leading edge, phase 1 on the trailing one
			assign next_shift = shift_in(shift_reg, bit_order,
				data_phase ? si[i] : sample_bit);

			// =========================================
			// shift engine; disable acts as a synchronous channel reset at the next clock edge
			always @(posedge clock) begin
				push <= 1'b0;
				sck_prev <= sck_in[i];
				if (rst || !enable) begin
					active <= 1'b0;
					shift_reg <= `CSP_RESET_VAL;
					bit_cnt <= 3'h0;
					sample_bit <= 1'b0;
					sck_drive <= clock_polarity;
					so_bit <= 1'b0;
				end else if (start) begin
					active <= 1'b1;
					bit_cnt <= 3'h0;
					sck_drive <= clock_polarity;
					if (txrx_mode) begin
						shift_reg <= bus_wdata;
						so_bit <= data_phase ? so_bit : out_bit(bus_wdata, bit_order);
					end else begin
						shift_reg <= shift_reg;
						so_bit <= 1'b0;
					end
				end else if (active) begin
					if (half_tick && !slave) begin
						sck_drive <= !sck_drive;
					end
					if (lead_edge) begin
						if (data_phase) begin
							so_bit <= out_bit(shift_reg, bit_order);
						end else begin
							sample_bit <= si[i];
						end
					end
					if (trail_edge) begin
						shift_reg <= next_shift;
						if (!data_phase) begin
							so_bit <= out_bit(next_shift, bit_order);
						end
						bit_cnt <= bit_cnt + 3'h1;
						if (bit_cnt == `CSP_BITS_LAST) begin
							active <= 1'b0;
							push <= 1'b1;
						end
					end
				end else begin
					sck_drive <= clock_polarity;
				end
			end

			// received bytes go to the fifo one cycle after the last edge
			csp_fifo #(
				.WIDTH(8),
				.DEPTH(`CSP_FIFO_DEPTH),
				.AW(`CSP_FIFO_AW)
			) u_fifo (
				.clock(clock),
				.rst(rst || !enable),
				.in_valid(push),
				.in_ready(fifo_in_ready),
				.in_data(shift_reg),
				.out_valid(rx_valid[i]),
				.out_ready(rx_ready[i]),
				.out_data(rx_data[8*i+7:8*i])
			);

			// =========================================
			// pins: data out is low in receive-only mode and while disabled
			assign so[i] = so_bit && txrx_mode && enable;
			assign sck_out[i] = sck_drive;
			// the clock pin is driven only by an enabled master
			assign sck_oe_n[i] = !(enable && !slave);

			assign mode_rd[i] = mode_val;
			assign clk_rd[i] = clk_val;
			assign shift_rd[i] = shift_reg;
			assign txbuf_rd[i] = transmit_buffer;
		end
	endgenerate

	// =========================================
	// registered read port; unmapped addresses read zero
	always @(posedge clock) begin
		if (rst) begin
			bus_rdata <= 8'h00;
		end else if (bus_rd) begin
			case (bus_addr)
				`CSP_MODE_CH0: bus_rdata <= mode_rd[0];
				`CSP_CLKSEL_CH0: bus_rdata <= clk_rd[0];
				`CSP_SHIFT_CH0: bus_rdata <= shift_rd[0];
				`CSP_TXBUF_CH0: bus_rdata <= txbuf_rd[0];
				`CSP_MODE_CH1: bus_rdata <= mode_rd[1];
				`CSP_CLKSEL_CH1: bus_rdata <= clk_rd[1];
				`CSP_SHIFT_CH1: bus_rdata <= shift_rd[1];
				`CSP_TXBUF_CH1: bus_rdata <= txbuf_rd[1];
				default: bus_rdata <= 8'h00;
			endcase
		end
	end
endmodule // csp_serial_ctrl

// ### bench/csp_peer.sv
`timescale 1ns/1ps

// =========================================
// far-side peripheral, timing type 1, msb first
module csp_peer (
	input wire sck,
	input wire mosi,
	input wire ld,
	input wire [7:0] ld_data,
	output wire miso,
	output reg [7:0] got
);
	reg [7:0] sh;
	assign miso = sh[7];
	// capture on leading edge, the master drives its first bit before it
	always @(posedge sck) begin
		got <= {got[6:0], mosi};
	end
	// change on trailing edge; spent bits become a toggling pattern, never a stale level
	always @(negedge sck or posedge ld) begin
		if (ld) begin
			sh <= ld_data;
		end else begin
			sh <= {sh[6:0], ~sh[0]};
		end
	end
endmodule // csp_peer

// ### bench/csp_serial_ctrl_properties.sv
`timescale 1ns/1ps
`include "csp_regs.vh"

// =========================================
// channel 0 checker, shadows mode from byte and bit writes and clock select from byte writes only
module csp_checker (
	input wire clock,
	input wire rst,
	input wire [15:0] bus_addr,
	input wire bus_wr,
	input wire [7:0] bus_wdata,
	input wire bus_bit_wr,
	input wire [2:0] bus_bit_sel,
	input wire bus_bit_val,
	input wire bus_rd,
	input wire [7:0] bus_rdata,
	input wire [1:0] sck_out,
	input wire [1:0] sck_oe_n,
	input wire [1:0] so,
	input wire [15:0] rx_data,
	input wire [1:0] rx_valid,
	input wire [1:0] rx_ready
);
	reg [7:0] m0;
	reg [7:0] c0;
	reg [7:0] gap;
	reg last;
	// shadow registers; gap counts cycles since the last clock pin change
	always @(posedge clock) begin
		if (rst) begin
			m0 <= 8'h00;
			c0 <= 8'h00;
			gap <= 8'hff;
		end else begin
			if (bus_wr && bus_addr == `CSP_MODE_CH0) m0 <= bus_wdata;
			if (bus_bit_wr && bus_addr == `CSP_MODE_CH0) m0[bus_bit_sel] <= bus_bit_val;
			if (bus_wr && bus_addr == `CSP_CLKSEL_CH0) c0 <= bus_wdata;
			gap <= (sck_out[0] != last) ? 8'h01 : (gap == 8'hff ? gap : gap + 8'h01);
		end
		last <= sck_out[0];
	end
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	a_reset_idle: assert property (disable iff (1'b0) rst |=> bus_rdata == 8'h00 &&
		sck_oe_n == 2'b11 && so == 2'b00 && rx_valid == 2'b00) else $error("reset state wrong");
	a_rxonly_low: assert property (!m0[6] |-> so[0] == 1'b0) else $error("so not low");
	a_oe_master: assert property (sck_oe_n[0] == !(m0[7] && c0[2:0] != `CSP_CLK_SLAVE))
		else $error("clock pin enable wrong");
	a_idle_level: assert property (!m0[7] && !$past(m0[7]) && $stable(c0) |->
		sck_out[0] == c0[4]) else $error("idle clock level wrong");
	a_write_starts: assert property (bus_wr && bus_addr == `CSP_TXBUF_CH0 &&
		m0[7:6] == 2'b11 && c0[2:0] == 3'h0 && gap > 8'd4 && !rx_valid[0]
		|-> ##[2:4] $changed(sck_out[0])) else $error("transfer did not start");
	a_half_period: assert property ($changed(sck_out[0]) && m0[7] && $past(m0[7]) &&
		c0[2:0] != `CSP_CLK_SLAVE |-> gap >= (8'd1 << c0[2:0])) else $error("clock too fast");
	a_fifo_hold: assert property (rx_valid[0] && !rx_ready[0] && !bus_wr && !bus_bit_wr
		|=> rx_valid[0] && $stable(rx_data[7:0])) else $error("fifo head dropped");
	a_rdata_hold: assert property (!bus_rd |=> $stable(bus_rdata)) else $error("rdata moved");
	a_mode_read: assert property (bus_rd && bus_addr == `CSP_MODE_CH0 |=>
		bus_rdata[7:1] == {$past(m0[7:6]), 1'b0, $past(m0[4]), 3'b000})
		else $error("mode readback wrong");
	c_start: cover property (bus_wr && bus_addr == `CSP_TXBUF_CH0 && m0[7:6] == 2'b11);
	c_rx: cover property (rx_valid[0] && rx_ready[0]);
	c_abort: cover property ($fell(m0[7]) && gap < 8'd8);
endmodule // csp_checker

bind csp_serial_ctrl csp_checker u_chk (.clock(clock), .rst(rst), .bus_addr(bus_addr),
	.bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_bit_wr(bus_bit_wr),
	.bus_bit_sel(bus_bit_sel), .bus_bit_val(bus_bit_val), .bus_rd(bus_rd),
	.bus_rdata(bus_rdata), .sck_out(sck_out), .sck_oe_n(sck_oe_n), .so(so),
	.rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready));

// ### bench/tb.sv
`timescale 1ns/1ps
`include "csp_regs.vh"

module tb;
	reg clock, rst, bus_wr, bus_bit_wr, bus_bit_val, bus_rd, ss_n, ld, pol;
	reg [15:0] bus_addr;
	reg [7:0] bus_wdata, ld_d, v;
	reg [2:0] bus_bit_sel;
	reg [1:0] rx_ready;
	reg [31:0] rows [0:8];
	wire [7:0] bus_rdata, got;
	wire [1:0] sck_out, sck_oe_n, so, rx_valid;
	wire [15:0] rx_data;
	wire miso;
	integer n_fail, n_checks, i, j, cyc;
	csp_serial_ctrl DUT (.clock(clock), .rst(rst), .bus_addr(bus_addr), .bus_wr(bus_wr),
		.bus_wdata(bus_wdata), .bus_bit_wr(bus_bit_wr), .bus_bit_sel(bus_bit_sel),
		.bus_bit_val(bus_bit_val), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .sck_in(2'b00),
		.sck_out(sck_out), .sck_oe_n(sck_oe_n), .si({1'b0, miso}), .so(so),
		.slave_select_in_n(ss_n), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready));
	// the peer is type 1; flipping its clock by the polarity bit also serves type 3
	csp_peer u_peer (.sck(sck_out[0] ^ pol), .mosi(so[0]), .ld(ld), .ld_data(ld_d), .miso(miso),
		.got(got));
	// =========================================
	// bus tasks, inputs move 1 ns after the edge
	task wr(input [15:0] a, input [7:0] d); begin
		@(posedge clock); #1 bus_addr = a; bus_wdata = d; bus_wr = 1;
		@(posedge clock); #1 bus_wr = 0;
	end endtask
	task bw(input [15:0] a, input [2:0] b, input x); begin
		@(posedge clock); #1 bus_addr = a; bus_bit_sel = b; bus_bit_val = x; bus_bit_wr = 1;
		@(posedge clock); #1 bus_bit_wr = 0;
	end endtask
	task rd(input [15:0] a, output [7:0] d); begin
		@(posedge clock); #1 bus_addr = a; bus_rd = 1;
		@(posedge clock); #1 bus_rd = 0;
		@(posedge clock); d = bus_rdata;
	end endtask
	task chk(input string nm, input [7:0] s, input [7:0] e); begin
		n_checks = n_checks + 1;
		if (s !== e) begin
			n_fail = n_fail + 1;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	end endtask
	function [7:0] rev(input [7:0] x); integer k; begin
		for (k = 0; k < 8; k = k + 1) rev[k] = x[7 - k];
	end endfunction
	// one byte on channel 0; mode and clock are only touched while idle
	task xfer(input [7:0] code, input [7:0] mode, input [7:0] tx, input [7:0] pat); begin
		wr(`CSP_MODE_CH0, 8'h00);
		wr(`CSP_CLKSEL_CH0, code);
		pol = code[4];
		ld_d = pat; ld = 1;
		wr(`CSP_MODE_CH0, mode);
		ld = 0;
		if (mode[6]) wr(`CSP_TXBUF_CH0, tx); else rd(`CSP_SHIFT_CH0, v);
		rd(`CSP_MODE_CH0, v);
		chk("active", {7'h0, v[0]}, 8'h01);
		for (j = 0; j < 200 && v[0]; j = j + 1) rd(`CSP_MODE_CH0, v);
		chk("done", {7'h0, v[0]}, 8'h00);
		chk("rxvalid", {7'h0, rx_valid[0]}, 8'h01);
		chk("rxbyte", rx_data[7:0], mode[4] ? rev(pat) : pat);
		chk("peer", got, mode[6] ? (mode[4] ? rev(tx) : tx) : 8'h00);
		if (mode[6]) rd(`CSP_SHIFT_CH0, v);
		if (mode[6]) chk("shift", v, mode[4] ? rev(pat) : pat);
		@(posedge clock); #1 rx_ready = 2'b01;
		@(posedge clock); #1 rx_ready = 2'b00;
		$display("test xfer %h %h done", code, mode);
	end endtask
	task end_sim; begin
		$display("checks %0d fails %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	end endtask
	initial begin
		clock = 0;
		forever #12.5 clock = ~clock;
	end
	always @(posedge clock) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			n_fail = n_fail + 1;
			end_sim;
		end
	end
	// =========================================
	// main sequence
	initial begin
		{bus_wr, bus_bit_wr, bus_bit_val, bus_rd, ld, bus_bit_sel} = 0;
		{bus_addr, bus_wdata, ld_d, rx_ready} = 0;
		rst = 1; ss_n = 1; n_fail = 0; n_checks = 0; cyc = 0; pol = 0;
		rows[0] = 32'hff80_df_d0; rows[1] = 32'hff80_00_00; rows[2] = 32'hff81_ff_1f;
		rows[3] = 32'hff81_00_00; rows[4] = 32'hff88_f1_f0; rows[5] = 32'hff88_00_00;
		rows[6] = 32'hff89_e7_07; rows[7] = 32'hff89_00_00; rows[8] = 32'hff8c_5a_00;
		repeat (8) @(posedge clock);
		#1 rst = 0;
		for (i = 0; i < 4; i = i + 1) begin
			rd(rows[2 * i][31:16], v);
			chk("reset", v, 8'h00);
		end
		$display("test reset done");
		for (i = 0; i < 9; i = i + 1) begin
			wr(rows[i][31:16], rows[i][15:8]);
			rd(rows[i][31:16], v);
			chk("table", v, rows[i][7:0]);
		end
		$display("test table done");
		bw(`CSP_MODE_CH0, 3'h7, 1'b1);
		bw(`CSP_MODE_CH0, 3'h0, 1'b1);
		rd(`CSP_MODE_CH0, v);
		chk("bitwr", v, 8'h80);
		$display("test bit write done");
		xfer(8'h00, 8'hc0, 8'ha5, 8'h3c);
		xfer(8'h12, 8'hc0, 8'h69, 8'hc3);
		xfer(8'h02, 8'hd0, 8'h1e, 8'h96);
		xfer(8'h00, 8'h80, 8'h00, 8'h5a);
		xfer(8'h02, 8'h90, 8'h00, 8'h1e);
		// abort mid-frame by clearing the enable bit
		wr(`CSP_MODE_CH0, 8'h00);
		wr(`CSP_CLKSEL_CH0, 8'h04);
		wr(`CSP_MODE_CH0, 8'hc0);
		wr(`CSP_TXBUF_CH0, 8'hff);
		repeat (40) @(posedge clock);
		wr(`CSP_MODE_CH0, 8'h00);
		rd(`CSP_MODE_CH0, v);
		chk("abort", v, 8'h00);
		rd(`CSP_SHIFT_CH0, v);
		chk("abortsh", v, 8'h00);
		$display("test abort done");
		// channel 1 slave with select held high then low, level fixed beforehand
		wr(`CSP_CLKSEL_CH1, 8'h07);
		wr(`CSP_MODE_CH1, 8'he0);
		wr(`CSP_TXBUF_CH1, 8'h55);
		rd(`CSP_MODE_CH1, v);
		chk("ssoff", v, 8'he0);
		#1 ss_n = 0;
		wr(`CSP_TXBUF_CH1, 8'h55);
		rd(`CSP_MODE_CH1, v);
		chk("sson", v, 8'he1);
		wr(`CSP_MODE_CH1, 8'h00);
		rd(`CSP_MODE_CH1, v);
		chk("ssstop", v, 8'h00);
		$display("test slave select done");
		end_sim;
	end
endmodule // tb
